// File: rtl/acfg_pkg.sv
// Constants, field layout and state codes of the amplifier configuration port.
// Assumes a 25 MHz local clock and an external two-wire bus master.
package acfg_pkg;
	localparam logic [6:0] DEV_ADDR       = 7'h2A; // Arbitrary value
	localparam logic [3:0] BYTE_BITS      = 4'h8;
	localparam logic [7:0] REG_LAST_ADDR  = 8'h00;
	localparam logic [7:0] REG_INPUT_CFG  = 8'h10;
	localparam logic [7:0] REG_LEFT       = 8'h20;
	localparam logic [7:0] REG_RIGHT      = 8'h21;
	localparam logic [7:0] REG_MODULATOR  = 8'h30;
	localparam logic [7:0] REG_SOFT_RESET = 8'hFF;
	localparam logic [7:0] SOFT_RESET_VAL = 8'hFF;
	localparam int         FMT_LSB        = 0;
	localparam int         RATE_LSB       = 3;
	localparam int         RATIO_LSB      = 5;
	localparam int         CFG_ZERO_BIT   = 7;
	localparam int         GAIN_LSB       = 0;
	localparam int         SOUND_BIT      = 6;
	localparam int         HALT_BIT       = 7;
	localparam int         MOD_LSB        = 1;
	localparam logic [7:0] INPUT_CFG_RST  = 8'h08;
	localparam logic [7:0] CHAN_RST       = 8'h00;
	localparam logic [2:0] MOD_RST        = 3'h1;
	localparam logic [5:0] GAIN_MUTE_CODE = 6'h00;
	localparam logic [2:0] FMT_I2S        = 3'h0;
	localparam logic [2:0] FMT_LEFT       = 3'h1;
	localparam logic [2:0] FMT_RIGHT_LSB  = 3'h2;
	localparam logic [2:0] FMT_R24        = 3'h3;
	localparam logic [2:0] FMT_R20        = 3'h4;
	localparam logic [2:0] FMT_R18        = 3'h5;
	localparam logic [2:0] FMT_R16        = 3'h6;
	localparam int         BITCLK_PER_FS  = 64;
	localparam int         SLOT_BITS      = 32;
	localparam int         MAX_DATA_BITS  = 24;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_RX     = 3'h1,
		ST_ACK    = 3'h2,
		ST_TX     = 3'h3,
		ST_RACK   = 3'h4,
		ST_IGNORE = 3'h5
	} acfg_state_t;
	typedef enum logic [1:0] {
		PH_ADDR = 2'h0,
		PH_REG  = 2'h1,
		PH_DATA = 2'h2
	} acfg_phase_t;
endpackage

// File: rtl/acfg_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one per bit.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/1ps
module acfg_pin_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rstn,
	// Pins
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	for (genvar g = 0; g < W; g++) begin : g_bit
		logic [2:0] sh_ff;
		logic       filt_ff;
		logic [2:0] nxt_sh;
		logic       nxt_filt;
		always_comb begin
			nxt_sh   = {sh_ff[1:0], i_async[g]};
			nxt_filt = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : filt_ff;
		end
		always_ff @(posedge i_mclk) begin
			if (!i_rstn) begin
				sh_ff   <= {3{INIT[g]}};
				filt_ff <= INIT[g];
			end else begin
				sh_ff   <= nxt_sh;
				filt_ff <= nxt_filt;
			end
		end
		assign o_sync[g] = filt_ff;
	end
endmodule

// File: rtl/acfg_reg_bank.sv
// Configuration register bank with soft reset and last-address capture.
// Assumes single-cycle write and access strobes from the serial port.
`timescale 1ns/1ps
module acfg_reg_bank (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	// Access from serial port
	input  wire logic       i_wr,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_acc,
	output logic      [7:0] o_rdata,
	// Fields
	output logic      [2:0] o_fmt,
	output logic      [1:0] o_rate,
	output logic      [1:0] o_ratio,
	output logic      [7:0] o_left,
	output logic      [7:0] o_right,
	output logic      [2:0] o_mod
);
	import acfg_pkg::*;
	logic [7:0] last_ff, cfg_ff, left_ff, right_ff;
	logic [2:0] mod_ff;
	logic [7:0] nxt_last, nxt_cfg, nxt_left, nxt_right;
	logic [2:0] nxt_mod;
	always_comb begin
		nxt_last  = last_ff;
		nxt_cfg   = cfg_ff;
		nxt_left  = left_ff;
		nxt_right = right_ff;
		nxt_mod   = mod_ff;
		if (i_acc)
			nxt_last = i_addr;
		if (i_wr) begin
			case (i_addr)
				REG_INPUT_CFG: nxt_cfg = {1'b0, i_wdata[CFG_ZERO_BIT-1:0]};
				REG_LEFT:      nxt_left = i_wdata;
				REG_RIGHT:     nxt_right = i_wdata;
				REG_MODULATOR: nxt_mod = i_wdata[MOD_LSB +: 3];
				REG_SOFT_RESET: begin
					if (i_wdata == SOFT_RESET_VAL) begin
						nxt_cfg   = INPUT_CFG_RST;
						nxt_left  = CHAN_RST;
						nxt_right = CHAN_RST;
						nxt_mod   = MOD_RST;
					end
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			last_ff  <= 8'h00;
			cfg_ff   <= INPUT_CFG_RST;
			left_ff  <= CHAN_RST;
			right_ff <= CHAN_RST;
			mod_ff   <= MOD_RST;
		end else begin
			last_ff  <= nxt_last;
			cfg_ff   <= nxt_cfg;
			left_ff  <= nxt_left;
			right_ff <= nxt_right;
			mod_ff   <= nxt_mod;
		end
	end
	always_comb begin
		case (i_addr)
			REG_LAST_ADDR: o_rdata = last_ff;
			REG_INPUT_CFG: o_rdata = cfg_ff;
			REG_LEFT:      o_rdata = left_ff;
			REG_RIGHT:     o_rdata = right_ff;
			REG_MODULATOR: o_rdata = {4'h0, mod_ff, 1'b1};
			default:       o_rdata = 8'h00;
		endcase
	end
	assign o_fmt   = cfg_ff[FMT_LSB +: 3];
	assign o_rate  = cfg_ff[RATE_LSB +: 2];
	assign o_ratio = cfg_ff[RATIO_LSB +: 2];
	assign o_left  = left_ff;
	assign o_right = right_ff;
	assign o_mod   = mod_ff;
endmodule

// File: rtl/acfg_i2c_slave.sv
// Two-wire slave control port of the amplifier with its configuration bank.
// Assumes an external master on open-drain clock and data lines at standard speed.
`timescale 1ns/1ps
module acfg_i2c_slave (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	// Serial bus
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_o,
	output logic            o_sda_oen,
	// Straps
	input  wire logic       i_combined_mode,
	input  wire logic [2:0] i_format_strap,
	// Configuration
	output logic      [2:0] o_input_format_select,
	output logic      [2:0] o_input_format_field,
	output logic      [1:0] o_sample_rate_class,
	output logic      [1:0] o_master_clock_ratio,
	output logic      [5:0] o_left_level_code,
	output logic            o_left_sound_on_n,
	output logic            o_left_output_halt,
	output logic      [5:0] o_right_level_code,
	output logic            o_right_sound_on_n,
	output logic            o_right_output_halt,
	output logic            o_idle_pulse_control,
	output logic            o_modulation_index_sel,
	output logic            o_shaper_order_sel
);
	import acfg_pkg::*;

	logic [1:0]  bus_s;
	logic [3:0]  strap_s;
	logic        scl_s, sda_s, rise, fall, start_det, stop_det;
	logic        scl_q_ff, sda_q_ff;
	acfg_state_t state_ff, nxt_state;
	acfg_phase_t phase_ff, nxt_phase;
	logic [3:0]  cnt_ff, nxt_cnt;
	logic [7:0]  shift_ff, nxt_shift;
	logic [7:0]  tx_ff, nxt_tx;
	logic [7:0]  reg_addr_ff, nxt_reg_addr;
	logic [7:0]  wdata_ff, nxt_wdata;
	logic        rw_ff, nxt_rw;
	logic        oen_ff, nxt_oen;
	logic        wr_ff, nxt_wr;
	logic        acc_ff, nxt_acc;
	logic        sda_o_ff;
	logic [2:0]  fmt_ff, nxt_fmt;
	logic [7:0]  rdata;
	logic [2:0]  reg_fmt, mod;
	logic [7:0]  left, right;

	// Pin synchronisers
	acfg_pin_sync #(
		.W    (2),
		.INIT (2'h3)
	) u_bus_sync (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_async ({i_scl, i_sda}),
		.o_sync  (bus_s)
	);
	acfg_pin_sync #(
		.W    (4),
		.INIT (4'h0)
	) u_strap_sync (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_async ({i_combined_mode, i_format_strap}),
		.o_sync  (strap_s)
	);

	// Register bank
	acfg_reg_bank u_bank (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_wr    (wr_ff),
		.i_addr  (reg_addr_ff),
		.i_wdata (wdata_ff),
		.i_acc   (acc_ff),
		.o_rdata (rdata),
		.o_fmt   (reg_fmt),
		.o_rate  (o_sample_rate_class),
		.o_ratio (o_master_clock_ratio),
		.o_left  (left),
		.o_right (right),
		.o_mod   (mod)
	);

	// Bus events
	assign scl_s     = bus_s[1];
	assign sda_s     = bus_s[0];
	assign rise      = scl_s && !scl_q_ff;
	assign fall      = !scl_s && scl_q_ff;
	assign start_det = scl_s && scl_q_ff && sda_q_ff && !sda_s;
	assign stop_det  = scl_s && scl_q_ff && !sda_q_ff && sda_s;

	// Protocol engine
	always_comb begin
		nxt_state    = state_ff;
		nxt_phase    = phase_ff;
		nxt_cnt      = cnt_ff;
		nxt_shift    = shift_ff;
		nxt_tx       = tx_ff;
		nxt_reg_addr = reg_addr_ff;
		nxt_wdata    = wdata_ff;
		nxt_rw       = rw_ff;
		nxt_oen      = oen_ff;
		nxt_wr       = 1'b0;
		nxt_acc      = 1'b0;
		if (stop_det) begin
			nxt_state = ST_IDLE;
			nxt_oen   = 1'b1;
		end else if (start_det) begin
			nxt_state = ST_RX;
			nxt_phase = PH_ADDR;
			nxt_cnt   = 4'h0;
			nxt_oen   = 1'b1;
		end else begin
			case (state_ff)
				ST_RX: begin
					if (rise) begin
						nxt_shift = {shift_ff[6:0], sda_s};
						nxt_cnt   = cnt_ff + 4'h1;
					end else if (fall && cnt_ff == BYTE_BITS) begin
						nxt_cnt = 4'h0;
						case (phase_ff)
							PH_ADDR: begin
								if (shift_ff[7:1] == DEV_ADDR) begin
									nxt_rw    = shift_ff[0];
									nxt_phase = PH_REG;
									nxt_oen   = 1'b0;
									nxt_state = ST_ACK;
								end else begin
									nxt_state = ST_IGNORE;
								end
							end
							PH_REG: begin
								nxt_reg_addr = shift_ff;
								nxt_phase    = PH_DATA;
								nxt_oen      = 1'b0;
								nxt_state    = ST_ACK;
							end
							default: begin
								nxt_wr    = 1'b1;
								nxt_acc   = 1'b1;
								nxt_wdata = shift_ff;
								nxt_oen   = 1'b0;
								nxt_state = ST_ACK;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (fall) begin
						if (rw_ff) begin
							nxt_tx    = rdata;
							nxt_oen   = rdata[7];
							nxt_acc   = 1'b1;
							nxt_cnt   = 4'h1;
							nxt_state = ST_TX;
						end else begin
							nxt_oen   = 1'b1;
							nxt_cnt   = 4'h0;
							nxt_state = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (fall) begin
						if (cnt_ff == BYTE_BITS) begin
							nxt_oen   = 1'b1;
							nxt_state = ST_RACK;
						end else begin
							nxt_tx  = {tx_ff[6:0], 1'b0};
							nxt_oen = tx_ff[6];
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (rise)
						nxt_state = sda_s ? ST_IGNORE : ST_ACK;
				end
				default: ;
			endcase
		end
	end

	// Format source select
	always_comb begin
		if (strap_s[3] && strap_s[2:0] == FMT_I2S)
			nxt_fmt = reg_fmt;
		else
			nxt_fmt = strap_s[2:0];
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			scl_q_ff    <= 1'b1;
			sda_q_ff    <= 1'b1;
			state_ff    <= ST_IDLE;
			phase_ff    <= PH_ADDR;
			cnt_ff      <= 4'h0;
			shift_ff    <= 8'h00;
			tx_ff       <= 8'h00;
			reg_addr_ff <= 8'h00;
			wdata_ff    <= 8'h00;
			rw_ff       <= 1'b0;
			oen_ff      <= 1'b1;
			wr_ff       <= 1'b0;
			acc_ff      <= 1'b0;
			sda_o_ff    <= 1'b0;
			fmt_ff      <= FMT_I2S;
		end else begin
			scl_q_ff    <= scl_s;
			sda_q_ff    <= sda_s;
			state_ff    <= nxt_state;
			phase_ff    <= nxt_phase;
			cnt_ff      <= nxt_cnt;
			shift_ff    <= nxt_shift;
			tx_ff       <= nxt_tx;
			reg_addr_ff <= nxt_reg_addr;
			wdata_ff    <= nxt_wdata;
			rw_ff       <= nxt_rw;
			oen_ff      <= nxt_oen;
			wr_ff       <= nxt_wr;
			acc_ff      <= nxt_acc;
			sda_o_ff    <= 1'b0;
			fmt_ff      <= nxt_fmt;
		end
	end

	// Outputs
	assign o_sda_o                = sda_o_ff;
	assign o_sda_oen              = oen_ff;
	assign o_input_format_select  = fmt_ff;
	assign o_input_format_field   = reg_fmt;
	assign o_left_level_code      = left[GAIN_LSB +: 6];
	assign o_left_sound_on_n      = left[SOUND_BIT];
	assign o_left_output_halt     = left[HALT_BIT];
	assign o_right_level_code     = right[GAIN_LSB +: 6];
	assign o_right_sound_on_n     = right[SOUND_BIT];
	assign o_right_output_halt    = right[HALT_BIT];
	assign o_idle_pulse_control   = mod[0];
	assign o_modulation_index_sel = mod[1];
	assign o_shaper_order_sel     = mod[2];

	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	sequence s_byte_done;
		state_ff == ST_RX && fall && cnt_ff == BYTE_BITS;
	endsequence
	sequence s_addr_hit;
		phase_ff == PH_ADDR && shift_ff[7:1] == DEV_ADDR;
	endsequence
	sequence s_addr_miss;
		phase_ff == PH_ADDR && shift_ff[7:1] != DEV_ADDR;
	endsequence

	property p_idle_release;
		state_ff == ST_IDLE || state_ff == ST_IGNORE |-> oen_ff;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("Data driven while idle");
	property p_start;
		start_det && !stop_det |=> state_ff == ST_RX && phase_ff == PH_ADDR && cnt_ff == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("Start not taken");
	property p_stop;
		stop_det |=> state_ff == ST_IDLE && oen_ff;
	endproperty
	a_stop: assert property (p_stop) else $error("Stop not taken");
	property p_ack;
		s_byte_done ##0 ((phase_ff != PH_ADDR) or s_addr_hit) |=> !oen_ff && state_ff == ST_ACK;
	endproperty
	a_ack: assert property (p_ack) else $error("Byte not acknowledged");
	property p_ack_hold;
		state_ff == ST_ACK && !oen_ff && !fall && !start_det && !stop_det |=> !oen_ff;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("Acknowledge dropped early");
	property p_write;
		s_byte_done ##0 phase_ff == PH_DATA |=> wr_ff && wdata_ff == $past(shift_ff) ##1 !wr_ff;
	endproperty
	a_write: assert property (p_write) else $error("Data byte not written");
	property p_read_load;
		state_ff == ST_ACK && fall && rw_ff && !start_det && !stop_det
			|=> state_ff == ST_TX && oen_ff == $past(rdata[7]) && tx_ff == $past(rdata);
	endproperty
	a_read_load: assert property (p_read_load) else $error("Read byte not loaded");
	property p_tx_bit;
		state_ff == ST_TX && fall && cnt_ff != BYTE_BITS |=> oen_ff == $past(tx_ff[6]);
	endproperty
	a_tx_bit: assert property (p_tx_bit) else $error("Wrong read bit driven");
	property p_nack;
		state_ff == ST_RACK && rise && sda_s && !stop_det |=> state_ff == ST_IGNORE;
	endproperty
	a_nack: assert property (p_nack) else $error("Missing acknowledge not honoured");
	property p_soft_reset;
		wr_ff && reg_addr_ff == REG_SOFT_RESET && wdata_ff == SOFT_RESET_VAL
			|=> o_idle_pulse_control && left == CHAN_RST && right == CHAN_RST
				&& o_sample_rate_class == INPUT_CFG_RST[RATE_LSB +: 2];
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("Soft reset incomplete");
	property p_cfg_bit7;
		reg_addr_ff == REG_INPUT_CFG |-> rdata[CFG_ZERO_BIT] == 1'b0;
	endproperty
	a_cfg_bit7: assert property (p_cfg_bit7) else $error("Config bit 7 not zero");
	property p_fmt_sel;
		strap_s[3] && strap_s[2:0] == FMT_I2S |=> fmt_ff == $past(reg_fmt);
	endproperty
	a_fmt_sel: assert property (p_fmt_sel) else $error("Format source wrong");
	property p_nomatch;
		s_byte_done ##0 s_addr_miss |=> state_ff == ST_IGNORE && oen_ff;
	endproperty
	a_nomatch: assert property (p_nomatch) else $error("Foreign address acknowledged");
endmodule

// File: tb/acfg_bus_master.sv
// Behavioural two-wire bus master: drives the bus clock and pulls data low.
// Assumes the bench resolves data with a pull-up; bit period 320 ns.
`timescale 1ns/1ps
module acfg_bus_master (
	// Bus
	output logic      o_scl,
	output logic      o_sda_low,
	input  wire logic i_sda
);
	initial begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end
	// One bit: long low so the port's synchronised answer lands before the rise
	task automatic bit_cyc(input logic b, output logic s);
		#80 o_sda_low = ~b;
		#120 o_scl = 1'b1;
		#120 s = i_sda;
		o_scl = 1'b0;
	endtask
	// Start or repeated start
	task automatic start;
		#80 o_sda_low = 1'b0;
		#80 o_scl = 1'b1;
		#160 o_sda_low = 1'b1;
		#160 o_scl = 1'b0;
	endtask
	// Stop, then bus left idle
	task automatic stop;
		#80 o_sda_low = 1'b1;
		#80 o_scl = 1'b1;
		#160 o_sda_low = 1'b0;
		#320;
	endtask
	// Byte out, then data released for the acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(b[i], s);
		end
		bit_cyc(1'b1, ack);
		#320;
	endtask
	// Byte in with data released, then no acknowledge
	task automatic recv_byte(output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(1'b1, b[i]);
		end
		bit_cyc(1'b1, s);
		#320;
	endtask
endmodule

// File: tb/test_acfg_i2c_slave.sv
// Self-checking bench of the two-wire configuration port.
// Assumes the master model acfg_bus_master and a pull-up on the data line.
`timescale 1ns/1ps
module test_acfg_i2c_slave;
	import acfg_pkg::*;
	logic       i_mclk;
	logic       i_rstn;
	logic       i_combined_mode;
	logic [2:0] i_format_strap;
	logic       scl;
	logic       m_low;
	logic       sda;
	logic       o_sda_o;
	logic       o_sda_oen;
	logic [2:0] fmt_sel;
	logic [2:0] fmt_fld;
	logic [1:0] rate;
	logic [1:0] ratio;
	logic [5:0] l_lvl;
	logic       l_snd;
	logic       l_halt;
	logic [5:0] r_lvl;
	logic       r_snd;
	logic       r_halt;
	logic       idle;
	logic       index;
	logic       shaper;
	int         n_errors;
	int         checks_done;

	// Open-drain data with pull-up
	assign sda = ~(m_low | (~o_sda_oen & ~o_sda_o));

	acfg_bus_master bm (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));

	acfg_i2c_slave uut (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda),
		.o_sda_o(o_sda_o), .o_sda_oen(o_sda_oen),
		.i_combined_mode(i_combined_mode), .i_format_strap(i_format_strap),
		.o_input_format_select(fmt_sel), .o_input_format_field(fmt_fld),
		.o_sample_rate_class(rate), .o_master_clock_ratio(ratio),
		.o_left_level_code(l_lvl), .o_left_sound_on_n(l_snd), .o_left_output_halt(l_halt),
		.o_right_level_code(r_lvl), .o_right_sound_on_n(r_snd), .o_right_output_halt(r_halt),
		.o_idle_pulse_control(idle), .o_modulation_index_sel(index), .o_shaper_order_sel(shaper)
	);

	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tx(input logic [7:0] b, input logic ex);
		logic a;
		bm.send_byte(b, a);
		chk({7'h00, a}, {7'h00, ex});
	endtask

	task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] wd, input logic ex);
		// Pin edges kept off the sampling edge
		@(negedge i_mclk);
		bm.start();
		tx({dev, 1'b0}, ex);
		tx(ra, ex);
		tx(wd, ex);
		bm.stop();
		repeat (8) @(posedge i_mclk);
	endtask

	task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
		logic [7:0] d;
		@(negedge i_mclk);
		bm.start();
		tx({DEV_ADDR, 1'b0}, 1'b0);
		tx(ra, 1'b0);
		bm.start();
		tx({DEV_ADDR, 1'b1}, 1'b0);
		bm.recv_byte(d);
		bm.stop();
		chk(d, exp);
		repeat (8) @(posedge i_mclk);
	endtask

	task automatic chk_fields(input logic [7:0] c, input logic [7:0] l, input logic [7:0] r, input logic [7:0] m);
		chk({1'b0, ratio, rate, fmt_fld}, c);
		chk({l_halt, l_snd, l_lvl}, l);
		chk({r_halt, r_snd, r_lvl}, r);
		chk({4'h0, shaper, index, idle, 1'b1}, m);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		n_errors++;
		end_sim();
	end

	initial begin
		n_errors = 0;
		checks_done = 0;
		i_rstn = 1'b0;
		i_combined_mode = 1'b1;
		i_format_strap = 3'h0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (8) @(posedge i_mclk);
		// Reset values on pins and over the bus
		chk({7'h00, o_sda_oen}, 8'h01);
		chk_fields(8'h08, 8'h00, 8'h00, 8'h03);
		rd_chk(REG_INPUT_CFG, 8'h08);
		rd_chk(REG_LEFT, 8'h00);
		rd_chk(REG_MODULATOR, 8'h03);
		$display("test reset values done");
		// Writes with readback
		wr_reg(DEV_ADDR, REG_INPUT_CFG, 8'hFF, 1'b0);
		wr_reg(DEV_ADDR, REG_LEFT, 8'hC5, 1'b0);
		wr_reg(DEV_ADDR, REG_RIGHT, 8'h7A, 1'b0);
		wr_reg(DEV_ADDR, REG_MODULATOR, 8'hFF, 1'b0);
		chk_fields(8'h7F, 8'hC5, 8'h7A, 8'h0F);
		rd_chk(REG_INPUT_CFG, 8'h7F);
		rd_chk(REG_LEFT, 8'hC5);
		rd_chk(REG_RIGHT, 8'h7A);
		rd_chk(REG_MODULATOR, 8'h0F);
		rd_chk(REG_LAST_ADDR, REG_MODULATOR);
		$display("test write and readback done");
		// Foreign address, read-only, unmapped and wrong soft-reset data
		wr_reg(DEV_ADDR ^ 7'h01, REG_LEFT, 8'h00, 1'b1);
		wr_reg(DEV_ADDR, REG_LAST_ADDR, 8'h00, 1'b0);
		wr_reg(DEV_ADDR, 8'h40, 8'h00, 1'b0);
		wr_reg(DEV_ADDR, REG_SOFT_RESET, 8'h7E, 1'b0);
		chk_fields(8'h7F, 8'hC5, 8'h7A, 8'h0F);
		rd_chk(8'h40, 8'h00);
		$display("test refused accesses done");
		// Every format code through the register path, then the strap path
		for (int f = 0; f < 7; f++) begin
			wr_reg(DEV_ADDR, REG_INPUT_CFG, {5'h01, f[2:0]}, 1'b0);
			chk({5'h00, fmt_sel}, {5'h00, f[2:0]});
		end
		i_format_strap <= 3'h5;
		repeat (10) @(posedge i_mclk);
		chk({5'h00, fmt_sel}, 8'h05);
		i_format_strap <= 3'h0;
		i_combined_mode <= 1'b0;
		repeat (10) @(posedge i_mclk);
		chk({5'h00, fmt_sel}, 8'h00);
		$display("test format select done");
		// Soft reset restores every field
		wr_reg(DEV_ADDR, REG_SOFT_RESET, SOFT_RESET_VAL, 1'b0);
		chk_fields(8'h08, 8'h00, 8'h00, 8'h03);
		rd_chk(REG_RIGHT, 8'h00);
		rd_chk(REG_SOFT_RESET, 8'h00);
		$display("test soft reset done");
		end_sim();
	end
endmodule
